// File: rtl/modem_port_pkg.sv
package modem_port_pkg;
	// timing, in the clock's own unit and in the ns figures they come from
	localparam int CLK_PERIOD_NS = 10;
	localparam int TX_CHIP_MIN_NS = 3000;
	localparam int TX_CHIP_MAX_NS = 3100;
	localparam int TX_CHIP_MIN_CYC = (TX_CHIP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TX_CHIP_MAX_CYC = TX_CHIP_MAX_NS / CLK_PERIOD_NS;
	// pin edge to state change: two sync flops plus the edge detect
	localparam int SYNC_LAT_CYC = 3;
	localparam int TX_LEAD_CYC = (TX_CHIP_MIN_CYC + TX_CHIP_MAX_CYC) / 2 - SYNC_LAT_CYC;
	localparam int TX_EXT_NS = 2000;
	localparam int TX_EXT_CYC = (TX_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BIT_NS = 1000;
	localparam int BIT_CYC = BIT_NS / CLK_PERIOD_NS;
	localparam int HALF_CYC = BIT_CYC / 2;

	localparam int FIFO_WIDTH = 1;
	localparam int FIFO_DEPTH = 16;

	// serial register port framing
	localparam logic [6:0] CHIP_ADDR = 7'h20;
	localparam logic [6:0] PTR_LAST = 7'h1F;
	localparam int REG_COUNT = 32;

	// register offsets
	localparam logic [6:0] REG_MODEM_CONTROL_RX_STATUS = 7'h01;
	localparam logic [6:0] REG_CHANNEL_ASSESS_CONTROL = 7'h02;
	localparam logic [6:0] REG_DIVERSITY_SIGNAL_LEVEL = 7'h03;
	localparam logic [6:0] REG_RX_SIGNAL_FIELD = 7'h04;
	localparam logic [6:0] REG_RX_LENGTH_HIGH = 7'h05;
	localparam logic [6:0] REG_RX_LENGTH_LOW = 7'h06;
	localparam logic [6:0] REG_RX_SERVICE_FIELD = 7'h07;
	localparam logic [6:0] REG_TX_GAIN_LENGTH_EXTENSION = 7'h11;
	localparam logic [6:0] REG_TX_LENGTH_HIGH = 7'h12;
	localparam logic [6:0] REG_TX_LENGTH_LOW = 7'h13;
	localparam logic [6:0] REG_LOW_GAIN_CALIBRATION = 7'h14;
	localparam logic [6:0] REG_HIGH_GAIN_CALIBRATION = 7'h15;
	localparam logic [6:0] REG_OPTIONS_FIRST = 7'h1C;
	localparam logic [6:0] REG_OPTIONS_SECOND = 7'h1D;

	// field layout and write masks
	localparam logic [7:0] MODE_WR_MASK = 8'hF0;
	localparam logic [7:0] DIVERSITY_WR_MASK = 8'h80;
	localparam logic [7:0] FULL_WR_MASK = 8'hFF;
	localparam int STAT_TX_ACTIVE_BIT = 0;
	localparam int STAT_RX_READY_BIT = 1;
	localparam int STAT_CLEAR_BIT = 2;
	localparam int ANTENNA_BIT = 7;
	localparam int LEN_EXT_BIT = 0;
	localparam logic [7:0] REG_RESET = 8'h00;

	// chip samples, offset binary around mid scale
	localparam logic [5:0] SAMPLE_MID = 6'h20;
	localparam logic [5:0] SAMPLE_POS = 6'h3E;
	localparam logic [5:0] SAMPLE_NEG = 6'h02;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_LEAD = 2'b01,
		TX_DATA = 2'b11,
		TX_EXT = 2'b10
	} tx_state_t;

	typedef enum logic [1:0] {
		SP_IDLE = 2'b00,
		SP_ADDR = 2'b01,
		SP_PTR = 2'b11,
		SP_DATA = 2'b10
	} spi_state_t;
endpackage

// File: rtl/bit_fifo.sv
`timescale 1ns/1ps
module bit_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_clear,
	// fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} fifo_state_t;

	fifo_state_t s;
	fifo_state_t n;
	logic push;
	logic pop;

	always_comb begin
		push = i_in_valid && o_in_ready;
		pop = i_out_ready && o_out_valid;
		n = s;
		if (i_clear) begin
			n.wr = '0;
			n.rd = '0;
			n.count = '0;
		end else begin
			if (push) begin
				n.mem[s.wr] = i_in_data;
				n.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
			end
			if (pop) begin
				n.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
			end
			n.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign o_in_ready = (s.count != (AW+1)'(DEPTH));
	assign o_out_valid = (s.count != '0);
	assign o_out_data = s.mem[s.rd];
endmodule

// File: rtl/modem_data_port.sv
`timescale 1ns/1ps
module modem_data_port (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_chip_reset,
	// controller data port
	input wire logic i_transmit_enable_in,
	input wire logic i_receive_enable_in,
	input wire logic i_transmit_serial_in,
	output logic o_transmit_ready_out,
	output logic o_receive_ready_out,
	output logic o_receive_serial_out,
	output logic o_payload_bit_clock,
	output logic o_channel_clear_out,
	output logic o_front_amp_gain_select,
	// serial register port
	input wire logic i_serial_port_select_n,
	input wire logic i_serial_port_clock,
	input wire logic i_serial_port_in,
	output logic o_serial_port_out,
	// demodulator and front end
	input wire logic i_demod_start,
	input wire logic i_demod_valid,
	input wire logic i_demod_bit,
	input wire logic i_demod_last,
	input wire logic i_energy_detect,
	input wire logic i_agc_high_gain,
	input wire logic [6:0] i_signal_level,
	input wire logic [7:0] i_rx_signal,
	input wire logic [15:0] i_rx_length,
	input wire logic [7:0] i_rx_service,
	// modulator and power
	output logic [5:0] o_analog_inphase_out,
	output logic [5:0] o_analog_quadrature_out,
	output logic o_chip_valid,
	output logic o_antenna_choice_out,
	output logic o_search_restart,
	output logic o_tx_powered,
	output logic o_rx_powered
);
	import modem_port_pkg::*;

	typedef struct packed {
		logic [2:0] txe_s;
		logic [2:0] rxe_s;
		logic [1:0] txd_s;
		logic [1:0] rst_s;
		logic [2:0] sclk_s;
		logic [2:0] cs_s;
		logic [1:0] sdi_s;
		tx_state_t tx_st;
		logic [8:0] tx_cnt;
		logic [6:0] chip_cnt;
		logic [16:0] taken;
		logic [16:0] sent;
		logic tx_ready;
		logic [5:0] i_smp;
		logic [5:0] q_smp;
		logic chip_valid;
		logic [6:0] dclk_cnt;
		logic dclk_on;
		logic dclk;
		logic rx_ready;
		logic rx_pend;
		logic rx_bit;
		logic rx_last;
		logic rx_fin;
		logic rx_out;
		logic restart;
		logic cca;
		logic gain;
		spi_state_t sp_st;
		logic [2:0] sp_cnt;
		logic [7:0] sp_sh;
		logic [6:0] ptr;
		logic autoinc;
		logic rd;
		logic sdo;
		logic [REG_COUNT-1:0][7:0] regs;
	} port_state_t;

	logic [1:0] rst_sync_q;
	logic rst_n;
	port_state_t s;
	port_state_t n;
	logic fifo_push;
	logic fifo_pop;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_data;
	logic tx_mode;
	logic rx_mode;
	logic sclk_fall;
	logic [16:0] tx_len;

	// reset enters asynchronously, leaves through two flops
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	function automatic logic [7:0] reg_value(input logic [6:0] a, input port_state_t st);
		logic [7:0] v;
		v = 8'h00;
		if (a == REG_MODEM_CONTROL_RX_STATUS) begin
			v = st.regs[a[4:0]] & MODE_WR_MASK;
			v[STAT_TX_ACTIVE_BIT] = (st.tx_st != TX_IDLE);
			v[STAT_RX_READY_BIT] = st.rx_ready;
			v[STAT_CLEAR_BIT] = st.cca;
		end else if (a == REG_DIVERSITY_SIGNAL_LEVEL) begin
			v = {st.regs[a[4:0]][ANTENNA_BIT], i_signal_level};
		end else if (a == REG_RX_SIGNAL_FIELD) begin
			v = i_rx_signal;
		end else if (a == REG_RX_LENGTH_HIGH) begin
			v = i_rx_length[15:8];
		end else if (a == REG_RX_LENGTH_LOW) begin
			v = i_rx_length[7:0];
		end else if (a == REG_RX_SERVICE_FIELD) begin
			v = i_rx_service;
		end else if (a <= PTR_LAST) begin
			v = st.regs[a[4:0]];
		end
		return v;
	endfunction

	function automatic logic [7:0] wr_mask(input logic [6:0] a);
		logic [7:0] m;
		m = 8'h00;
		if (a == REG_MODEM_CONTROL_RX_STATUS) begin
			m = MODE_WR_MASK;
		end else if (a == REG_DIVERSITY_SIGNAL_LEVEL) begin
			m = DIVERSITY_WR_MASK;
		end else if (a == REG_CHANNEL_ASSESS_CONTROL || a == REG_TX_GAIN_LENGTH_EXTENSION ||
			a == REG_TX_LENGTH_HIGH || a == REG_TX_LENGTH_LOW ||
			a == REG_LOW_GAIN_CALIBRATION || a == REG_HIGH_GAIN_CALIBRATION ||
			a == REG_OPTIONS_FIRST || a == REG_OPTIONS_SECOND) begin
			m = FULL_WR_MASK;
		end
		return m;
	endfunction

	function automatic logic [6:0] ptr_next(input logic [6:0] p);
		return (p == PTR_LAST) ? 7'h00 : p + 7'h01;
	endfunction

	// transmit wins when both enables are high
	assign tx_mode = s.txe_s[1];
	assign rx_mode = s.rxe_s[1] && !s.txe_s[1];
	assign sclk_fall = s.sclk_s[2] && !s.sclk_s[1];
	assign tx_len = {s.regs[REG_TX_GAIN_LENGTH_EXTENSION[4:0]][LEN_EXT_BIT],
		s.regs[REG_TX_LENGTH_HIGH[4:0]], s.regs[REG_TX_LENGTH_LOW[4:0]]};

	always_comb begin
		logic tx_rise;
		logic tx_fall;
		logic chip_tick;
		logic chip_bit;
		logic sclk_rise;
		logic [7:0] byte_in;
		logic [6:0] np;
		tx_rise = s.txe_s[1] && !s.txe_s[2];
		tx_fall = !s.txe_s[1] && s.txe_s[2];
		sclk_rise = s.sclk_s[1] && !s.sclk_s[2];
		byte_in = {s.sp_sh[6:0], s.sdi_s[1]};
		np = s.autoinc ? ptr_next(s.ptr) : s.ptr;
		chip_tick = 1'b0;
		chip_bit = 1'b1;
		fifo_push = 1'b0;
		fifo_pop = 1'b0;
		n = s;
		n.txe_s = {s.txe_s[1:0], i_transmit_enable_in};
		n.rxe_s = {s.rxe_s[1:0], i_receive_enable_in};
		n.txd_s = {s.txd_s[0], i_transmit_serial_in};
		n.rst_s = {s.rst_s[0], i_chip_reset};
		n.sclk_s = {s.sclk_s[1:0], i_serial_port_clock};
		n.cs_s = {s.cs_s[1:0], i_serial_port_select_n};
		n.sdi_s = {s.sdi_s[0], i_serial_port_in};
		n.chip_valid = 1'b0;
		n.restart = 1'b0;

		// transmit sequencer
		if (s.chip_cnt == 7'(BIT_CYC - 1)) begin
			n.chip_cnt = 7'h00;
			chip_tick = (s.tx_st == TX_DATA) || (s.tx_st == TX_EXT);
		end else begin
			n.chip_cnt = s.chip_cnt + 7'h01;
		end
		if (chip_tick && s.tx_st == TX_DATA && fifo_out_valid && s.sent < tx_len) begin
			fifo_pop = 1'b1;
			chip_bit = fifo_out_data;
			n.sent = s.sent + 17'h00001;
		end
		case (s.tx_st)
			TX_IDLE: begin
				if (tx_rise) begin
					n.tx_st = TX_LEAD;
					n.tx_cnt = 9'h000;
					n.sent = 17'h00000;
					n.taken = 17'h00000;
				end
			end
			TX_LEAD: begin
				n.tx_cnt = s.tx_cnt + 9'h001;
				if (tx_fall) begin
					n.tx_st = TX_IDLE;
				end else if (s.tx_cnt == 9'(TX_LEAD_CYC - 1)) begin
					n.tx_st = TX_DATA;
					chip_tick = 1'b1;
					n.chip_cnt = 7'h00;
					n.tx_ready = (tx_len != 17'h00000);
					n.dclk_cnt = 7'h00;
					n.dclk_on = (tx_len != 17'h00000);
				end
			end
			TX_DATA: begin
				if (tx_fall || (tx_len != 17'h00000 && s.sent == tx_len)) begin
					n.tx_st = TX_EXT;
					n.tx_cnt = 9'h000;
					n.tx_ready = 1'b0;
					n.dclk_on = 1'b0;
				end
			end
			TX_EXT: begin
				n.tx_cnt = s.tx_cnt + 9'h001;
				if (s.tx_cnt == 9'(TX_EXT_CYC - 1)) begin
					n.tx_st = TX_IDLE;
				end
			end
			default: n.tx_st = TX_IDLE;
		endcase
		if (chip_tick) begin
			n.chip_valid = 1'b1;
			n.i_smp = chip_bit ? SAMPLE_POS : SAMPLE_NEG;
			n.q_smp = chip_bit ? SAMPLE_NEG : SAMPLE_POS;
		end else if (s.tx_st == TX_IDLE) begin
			n.i_smp = SAMPLE_MID;
			n.q_smp = SAMPLE_MID;
		end

		// shared bit clock: a period runs only when it carries a bit
		if (s.tx_st == TX_DATA || rx_mode) begin
			n.dclk_cnt = (s.dclk_cnt == 7'(BIT_CYC - 1)) ? 7'h00 : s.dclk_cnt + 7'h01;
		end else if (s.tx_st != TX_LEAD || s.tx_cnt != 9'(TX_LEAD_CYC - 1)) begin
			n.dclk_cnt = 7'h00;
			n.dclk_on = 1'b0;
		end
		if (s.tx_st == TX_DATA && s.dclk_on && s.dclk_cnt == 7'(HALF_CYC)) begin
			fifo_push = 1'b1;
			n.taken = s.taken + 17'h00001;
		end
		if (s.dclk_cnt == 7'(BIT_CYC - 1)) begin
			if (s.tx_st == TX_DATA) begin
				// stall the clock while the buffer is full
				n.dclk_on = s.tx_ready && s.taken < tx_len && fifo_in_ready;
				n.tx_ready = s.tx_ready && s.taken < tx_len;
			end else if (s.rx_fin) begin
				n.rx_ready = 1'b0;
				n.restart = 1'b1;
				n.rx_fin = 1'b0;
				n.dclk_on = 1'b0;
			end else begin
				n.dclk_on = s.rx_pend;
				if (s.rx_pend) begin
					n.rx_out = s.rx_bit;
					n.rx_pend = 1'b0;
					n.rx_fin = s.rx_last;
				end
			end
		end
		n.dclk = n.dclk_on && (n.dclk_cnt >= 7'(HALF_CYC));

		// receive path
		if (rx_mode) begin
			if (i_demod_start && !s.rx_ready) begin
				n.rx_ready = 1'b1;
			end
			if (i_demod_valid && s.rx_ready && !s.rx_fin) begin
				n.rx_pend = 1'b1;
				n.rx_bit = i_demod_bit;
				n.rx_last = i_demod_last;
			end
		end else begin
			n.rx_ready = 1'b0;
			n.rx_pend = 1'b0;
			n.rx_fin = 1'b0;
		end
		n.cca = rx_mode && !i_energy_detect;
		n.gain = rx_mode && i_agc_high_gain;

		// serial register port
		if (s.cs_s[1]) begin
			n.sp_st = SP_IDLE;
			n.sp_cnt = 3'h0;
		end else if (s.cs_s[2]) begin
			n.sp_st = SP_ADDR;
			n.sp_cnt = 3'h0;
		end else if (sclk_rise) begin
			n.sp_cnt = s.sp_cnt + 3'h1;
			if (!(s.sp_st == SP_DATA && s.rd)) begin
				n.sp_sh = byte_in;
			end
			case (s.sp_st)
				SP_ADDR: begin
					if (s.sp_cnt == 3'h7) begin
						if (s.sp_sh[6:0] != CHIP_ADDR) begin
							n.sp_st = SP_IDLE;
						end else if (s.sdi_s[1]) begin
							n.rd = 1'b1;
							n.sp_st = SP_DATA;
							n.sp_sh = reg_value(s.ptr, s);
						end else begin
							n.rd = 1'b0;
							n.sp_st = SP_PTR;
						end
					end
				end
				SP_PTR: begin
					if (s.sp_cnt == 3'h7) begin
						n.autoinc = byte_in[7];
						n.ptr = byte_in[6:0];
						n.sp_st = SP_DATA;
					end
				end
				SP_DATA: begin
					if (s.sp_cnt == 3'h7) begin
						n.ptr = np;
						if (s.rd) begin
							n.sp_sh = reg_value(np, s);
						end else if (s.ptr <= PTR_LAST) begin
							n.regs[s.ptr[4:0]] = (s.regs[s.ptr[4:0]] & ~wr_mask(s.ptr)) |
								(byte_in & wr_mask(s.ptr));
						end
					end
				end
				default: n.sp_st = SP_IDLE;
			endcase
		end else if (sclk_fall && s.sp_st == SP_DATA && s.rd) begin
			n.sdo = s.sp_sh[7];
			n.sp_sh = {s.sp_sh[6:0], 1'b0};
		end

		// the reset pin holds everything except the input sync chains of all seven pins
		if (s.rst_s[1]) begin
			n = '0;
			n.txe_s = {s.txe_s[1:0], i_transmit_enable_in};
			n.rxe_s = {s.rxe_s[1:0], i_receive_enable_in};
			n.txd_s = {s.txd_s[0], i_transmit_serial_in};
			n.rst_s = {s.rst_s[0], i_chip_reset};
			n.sclk_s = {s.sclk_s[1:0], i_serial_port_clock};
			n.cs_s = {s.cs_s[1:0], i_serial_port_select_n};
			n.sdi_s = {s.sdi_s[0], i_serial_port_in};
			n.i_smp = SAMPLE_MID;
			n.q_smp = SAMPLE_MID;
			fifo_push = 1'b0;
			fifo_pop = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	bit_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_clear(s.tx_st == TX_IDLE),
		.i_in_valid(fifo_push),
		.o_in_ready(fifo_in_ready),
		.i_in_data(s.txd_s[1]),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_pop),
		.o_out_data(fifo_out_data)
	);

	assign o_transmit_ready_out = s.tx_ready;
	assign o_receive_ready_out = s.rx_ready;
	assign o_receive_serial_out = s.rx_out;
	assign o_payload_bit_clock = s.dclk;
	assign o_channel_clear_out = s.cca;
	assign o_front_amp_gain_select = s.gain;
	assign o_serial_port_out = s.sdo;
	assign o_analog_inphase_out = s.i_smp;
	assign o_analog_quadrature_out = s.q_smp;
	assign o_chip_valid = s.chip_valid;
	assign o_antenna_choice_out = s.regs[REG_DIVERSITY_SIGNAL_LEVEL[4:0]][ANTENNA_BIT];
	assign o_search_restart = s.restart;
	assign o_tx_powered = tx_mode;
	assign o_rx_powered = rx_mode;

	localparam int CHK_CHIP_LO = 297;
	localparam int CHK_CHIP_HI = 307;
	localparam int CHK_EXT_LO = 195;
	localparam int CHK_EXT_HI = 205;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!rst_n);

	chk_first_chip_time: assert property (
		(s.tx_st == TX_LEAD && $past(s.tx_st) == TX_IDLE) |->
		##[CHK_CHIP_LO:CHK_CHIP_HI] (s.chip_valid || s.tx_st == TX_IDLE))
		else $error("first chip outside window");
	chk_ext_length: assert property (
		(s.tx_st == TX_EXT && $past(s.tx_st) == TX_DATA) |->
		##[CHK_EXT_LO:CHK_EXT_HI] (s.tx_st == TX_IDLE))
		else $error("extension length wrong");
	chk_clear_rx_only: assert property (
		o_channel_clear_out |-> $past(rx_mode) && !$past(i_energy_detect))
		else $error("channel clear without receive");
	chk_gain_low_tx: assert property (
		tx_mode |=> !o_front_amp_gain_select)
		else $error("high gain while transmitting");
	chk_ptr_wrap: assert property (
		(s.sp_st == SP_DATA && s.autoinc && s.ptr == PTR_LAST && s.sp_cnt == 3'h7 &&
		!s.cs_s[1] && !s.cs_s[2] && s.sclk_s[1] && !s.sclk_s[2] && !s.rst_s[1]) |=>
		(s.ptr == 7'h00))
		else $error("pointer did not wrap");
	chk_out_on_fall: assert property (
		$changed(o_serial_port_out) |-> $past(sclk_fall) || $past(s.rst_s[1]))
		else $error("serial out moved off a falling edge");
	chk_reset_hold: assert property (
		s.rst_s[1] |=> !o_transmit_ready_out && !o_receive_ready_out && s.tx_st == TX_IDLE)
		else $error("activity during reset pin");
	chk_rx_ready_cause: assert property (
		$rose(o_receive_ready_out) |-> $past(i_demod_start) && $past(rx_mode))
		else $error("receive ready without packet start");
	chk_restart_after_last: assert property (
		o_search_restart |=> !o_receive_ready_out)
		else $error("ready held after search restart");
	chk_tx_ready_state: assert property (
		o_transmit_ready_out |-> s.tx_st == TX_DATA)
		else $error("transmit ready outside data phase");
endmodule

// File: testbench/mac_model.sv
`timescale 1ns/1ps
module mac_model #(
	parameter logic [3:0] PATTERN = 4'b1011
) (
	// clock
	input wire logic i_clk,
	// data port from the modem
	input wire logic i_payload_bit_clock,
	input wire logic i_transmit_ready_out,
	input wire logic i_receive_ready_out,
	input wire logic i_receive_serial_out,
	// data port to the modem and what was captured
	output logic o_transmit_serial_in,
	output logic o_rx_bit
);
	logic clk_q;
	logic rdy_q;
	int idx;

	initial begin
		clk_q = 1'b0;
		rdy_q = 1'b0;
		idx = 0;
		o_rx_bit = 1'b0;
		o_transmit_serial_in = 1'b0;
	end

	// the line toggles while not requested so a stale bit can never pass
	always @(posedge i_clk) begin
		#1;
		if (i_transmit_ready_out !== 1'b1) begin
			idx = 0;
			o_transmit_serial_in = ~o_transmit_serial_in;
		end else if (!rdy_q) begin
			o_transmit_serial_in = PATTERN[3];
		end else if (clk_q && !i_payload_bit_clock) begin
			idx++;
			o_transmit_serial_in = (idx < 4) ? PATTERN[3-idx] : ~o_transmit_serial_in;
		end
		if (!clk_q && i_payload_bit_clock && i_receive_ready_out) begin
			o_rx_bit = i_receive_serial_out;
		end
		clk_q = i_payload_bit_clock;
		rdy_q = (i_transmit_ready_out === 1'b1);
	end
endmodule

// File: testbench/modem_data_port_bench.sv
`timescale 1ns/1ps
module modem_data_port_bench;
	import modem_port_pkg::*;
	localparam logic [3:0] PAT = 4'b1011;
	logic clk, arst_n, chip_rst, txe, rxe, sel_n, sclk, sdi, d_start, d_valid, d_bit, d_last;
	logic energy, agc, tx_rdy, rx_rdy, rx_ser, pclk, cc, gain, sdo, chip_v, ant, restart;
	logic txp, rxp, tx_ser, rx_bit, seen;
	logic [5:0] ai, aq;
	logic [6:0] lvl = 7'h35;
	logic [7:0] rsig = 8'h0A;
	logic [15:0] rlen = 16'h1234;
	logic [7:0] rsvc = 8'h5C;
	logic [7:0] r;
	logic [7:0] q[$];
	int failures, checks, n;

	modem_data_port u_dut (.i_clk(clk), .i_arst_n(arst_n), .i_chip_reset(chip_rst),
		.i_transmit_enable_in(txe), .i_receive_enable_in(rxe), .i_transmit_serial_in(tx_ser),
		.o_transmit_ready_out(tx_rdy), .o_receive_ready_out(rx_rdy),
		.o_receive_serial_out(rx_ser), .o_payload_bit_clock(pclk), .o_channel_clear_out(cc),
		.o_front_amp_gain_select(gain), .i_serial_port_select_n(sel_n),
		.i_serial_port_clock(sclk), .i_serial_port_in(sdi), .o_serial_port_out(sdo),
		.i_demod_start(d_start), .i_demod_valid(d_valid), .i_demod_bit(d_bit),
		.i_demod_last(d_last), .i_energy_detect(energy), .i_agc_high_gain(agc),
		.i_signal_level(lvl), .i_rx_signal(rsig), .i_rx_length(rlen), .i_rx_service(rsvc),
		.o_analog_inphase_out(ai), .o_analog_quadrature_out(aq), .o_chip_valid(chip_v),
		.o_antenna_choice_out(ant), .o_search_restart(restart), .o_tx_powered(txp),
		.o_rx_powered(rxp));

	mac_model #(.PATTERN(PAT)) u_mac (.i_clk(clk), .i_payload_bit_clock(pclk),
		.i_transmit_ready_out(tx_rdy), .i_receive_ready_out(rx_rdy),
		.i_receive_serial_out(rx_ser), .o_transmit_serial_in(tx_ser), .o_rx_bit(rx_bit));

	task automatic complete_run;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t %s: %h vs %h", $time, msg, got, exp);
		end
	endtask

	// 80 ns link clock: 50 ns low so the reply has settled, 30 ns high
	task automatic sp_send(input logic [7:0] b, output logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			sdi = b[i];
			sclk = 1'b0;
			tick(5);
			v[i] = sdo;
			sclk = 1'b1;
			tick(3);
		end
	endtask

	task automatic sp_open(input logic [6:0] chip, input logic rw, input logic [7:0] ptr);
		logic [7:0] v;
		sel_n = 1'b0;
		tick(3);
		sp_send({chip, rw}, v);
		if (!rw) sp_send(ptr, v);
	endtask

	task automatic sp_close;
		sclk = 1'b0;
		tick(3);
		sel_n = 1'b1;
		sdi = ~sdi;
		tick(120);
	endtask

	task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
		logic [7:0] v;
		sp_open(CHIP_ADDR, 1'b0, ptr);
		foreach (d[i]) sp_send(d[i], v);
		sp_close;
	endtask

	task automatic rd_check(input logic [6:0] ptr, input logic [7:0] e[$], input string msg);
		logic [7:0] v;
		sp_open(CHIP_ADDR, 1'b0, {1'b1, ptr});
		sp_close;
		sp_open(CHIP_ADDR, 1'b1, 8'h00);
		q = {};
		repeat (e.size()) begin
			sp_send(8'h00, v);
			q.push_back(v);
		end
		sp_close;
		foreach (e[i]) check(q[i], e[i], msg);
	endtask

	task automatic wait_chip(input int lim);
		int c;
		c = 0;
		seen = 1'b0;
		while (!seen && c < lim) begin
			tick(1);
			c++;
			seen = (chip_v === 1'b1);
		end
	endtask

	task automatic tx_start(input string msg);
		int c;
		txe = 1'b1;
		c = 0;
		while (chip_v !== 1'b1 && c < 400) begin
			tick(1);
			c++;
		end
		check(8'(c >= TX_CHIP_MIN_CYC && c <= TX_CHIP_MAX_CYC), 8'h01, msg);
		check(8'(tx_rdy), 8'h01, "ready at first chip");
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (45000) @(posedge clk);
		failures++;
		$display("MISMATCH %0t run did not finish", $time);
		complete_run;
	end

	initial begin
		{arst_n, chip_rst, txe, rxe, sclk, sdi, d_start, d_valid, d_bit, d_last} = '0;
		{energy, agc, failures, checks} = '0;
		sel_n = 1'b1;
		tick(16);
		arst_n = 1'b1;
		tick(10000);
		rd_check(7'h11, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, "reset value");
		wr(8'h91, '{8'h5A, 8'hA5, 8'h3C, 8'hC3, 8'h0F});
		rd_check(7'h11, '{8'h5A, 8'hA5, 8'h3C, 8'hC3, 8'h0F}, "rw registers");
		wr(8'h9D, '{8'hA5, 8'hFF, 8'hFF, 8'hFF, 8'hFF});
		rd_check(7'h1D, '{8'hA5, 8'h00, 8'h00, 8'h00, 8'hF0}, "pointer wrap");
		wr(8'h83, '{8'hFF});
		rd_check(7'h03, '{{1'b1, lvl}, rsig, rlen[15:8], rlen[7:0], rsvc}, "status");
		check(8'(ant), 8'h01, "antenna select");
		sp_open(7'h21, 1'b0, 8'h9C);
		sp_send(8'hFF, r);
		sp_close;
		rd_check(7'h1C, '{8'h00}, "foreign chip address");
		wr(8'h9C, '{8'h66});
		chip_rst = 1'b1;
		tick(5);
		chip_rst = 1'b0;
		tick(10);
		rd_check(7'h1C, '{8'h00}, "reset pin");
		wr(8'h91, '{8'h00, 8'h00, 8'h04});
		tx_start("first chip delay");
		check(8'({cc, gain, txp}), 8'h01, "transmit mode outputs");
		for (int k = 3; k >= 0; k--) begin
			wait_chip(120);
			check({2'b00, ai}, PAT[k] ? SAMPLE_POS : SAMPLE_NEG, "in-phase chip");
			check({2'b00, aq}, PAT[k] ? SAMPLE_NEG : SAMPLE_POS, "quadrature chip");
		end
		for (n = 0; n < 300 && tx_rdy === 1'b1; n++) tick(1);
		check(8'(tx_rdy), 8'h00, "ready drop");
		wait_chip(250);
		check(8'(seen), 8'h01, "extension chips");
		tick(600);
		wait_chip(300);
		check(8'(seen), 8'h00, "held enable starts nothing");
		check({2'b00, ai}, SAMPLE_MID, "idle sample");
		txe = 1'b0;
		tick(150);
		tx_start("fresh rise");
		txe = 1'b0;
		tick(5);
		check(8'(tx_rdy), 8'h00, "enable fall ends data");
		tick(595);
		rxe = 1'b1;
		agc = 1'b1;
		tick(6);
		check(8'({rxp, cc, gain}), 8'h07, "receive clear high gain");
		energy = 1'b1;
		agc = 1'b0;
		tick(3);
		check(8'({cc, gain}), 8'h00, "busy low gain");
		d_start = 1'b1;
		tick(1);
		d_start = 1'b0;
		check(8'(rx_rdy), 8'h01, "receive ready");
		tick(4);
		{d_valid, d_bit, d_last} = 3'b111;
		tick(1);
		{d_valid, d_last} = 2'b00;
		for (n = 0; n < 400 && restart !== 1'b1; n++) tick(1);
		check(8'(restart), 8'h01, "search restart");
		check(8'(rx_bit), 8'h01, "received bit");
		tick(2);
		check(8'(rx_rdy), 8'h00, "ready after last bit");
		rxe = 1'b0;
		complete_run;
	end
endmodule
